// ==== core/cpu_external_bus_interface.sv ====
`timescale 1ns/1ps
`include "bus_port_defines.svh"

module cpu_external_bus_interface
    import bus_port_pkg::*;
#(
    parameter int ADDR_W = `ADDR_WIDTH,
    parameter int DATA_W = `DATA_WIDTH
) (
    input  wire logic                     clk_in,
    input  wire logic                     sys_rst_in,
    // Core side cycle request
    input  wire logic                     cyc_req_in,
    input  wire bus_port_pkg::cycle_kind_t cyc_kind_in,
    input  wire logic [ADDR_W-1:0]        cyc_addr_in,
    input  wire logic [DATA_W-1:0]        cyc_wdata_in,
    input  wire logic                     cyc_onchip_in,
    input  wire logic [DATA_W-1:0]        onchip_rdata_in,
    output logic                          cyc_ready_out,
    output logic                          cyc_done_out,
    output logic [DATA_W-1:0]             cyc_rdata_out,
    input  wire logic                     emulation_float_mode_in,
    input  wire logic                     slave_mode_in,
    // Pins
    input  wire logic [ADDR_W-1:0]        addr_in,
    output logic [ADDR_W-1:0]             addr_out,
    output logic                          addr_oe_out,
    input  wire logic [DATA_W-1:0]        data_in,
    output logic [DATA_W-1:0]             data_out,
    output logic                          data_oe_out,
    input  wire logic                     read_n_in,
    output logic                          read_n_out,
    output logic                          read_n_oe_out,
    input  wire logic                     write_n_in,
    output logic                          write_n_out,
    output logic                          write_n_oe_out,
    output logic                          memory_request_n_out,
    output logic                          memory_request_n_oe_out,
    input  wire logic                     io_request_n_in,
    output logic                          io_request_n_out,
    output logic                          io_request_n_oe_out,
    output logic                          first_machine_cycle_n_out,
    output logic                          first_machine_cycle_n_oe_out,
    output logic                          refresh_strobe_n_out,
    output logic                          refresh_strobe_n_oe_out,
    input  wire logic                     hold_request_n_in,
    output logic                          hold_grant_n_out,
    input  wire logic                     wait_n_in,
    // Outside master access to on-chip peripherals
    output logic                          slave_rd_out,
    output logic                          slave_wr_out,
    output logic [ADDR_W-1:0]             slave_addr_out,
    output logic [DATA_W-1:0]             slave_wdata_out
);

    bus_state_t  state;
    bus_state_t  next_state;
    cycle_kind_t kind;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic              onchip_q;
    logic [`REFRESH_ADDR_WIDTH-1:0] refresh_addr;
    logic              hold_grant;

    wire is_fetch   = (kind == CYC_FETCH);
    wire is_iack    = (kind == CYC_INT_ACK);
    wire is_io      = (kind == CYC_IO_READ) || (kind == CYC_IO_WRITE) || is_iack;
    wire is_write   = (kind == CYC_MEM_WRITE) || (kind == CYC_IO_WRITE);
    wire is_read    = !is_write && !is_iack;
    wire hold_req   = !hold_request_n_in;
    wire wait_act   = !wait_n_in;
    wire in_cycle   = (state == ST_T1) || (state == ST_T2) || (state == ST_TW)
                      || (state == ST_T3);
    wire in_strobe  = (state == ST_T2) || (state == ST_TW) || (state == ST_T3);
    wire in_refresh = (state == ST_REFRESH);
    wire floated    = hold_grant || slave_mode_in;

    // Sequencer: T1 -> T2 -> wait states -> T3, refresh after each fetch
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (hold_req) begin
                    next_state = ST_HOLD;
                end else if (cyc_req_in && !slave_mode_in) begin
                    next_state = ST_T1;
                end
            end
            ST_T1: next_state = ST_T2;
            ST_T2: next_state = wait_act ? ST_TW : ST_T3;
            ST_TW: next_state = wait_act ? ST_TW : ST_T3;
            ST_T3: next_state = is_fetch ? ST_REFRESH : ST_IDLE;
            ST_REFRESH: next_state = ST_IDLE;
            ST_HOLD: next_state = hold_req ? ST_HOLD : ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state        <= ST_IDLE;
            kind         <= CYC_FETCH;
            addr_q       <= `ADDR_RESET;
            wdata_q      <= `DATA_RESET;
            onchip_q     <= 1'b0;
            refresh_addr <= `REFRESH_RESET;
            hold_grant   <= 1'b0;
        end else begin
            state      <= next_state;
            hold_grant <= (next_state == ST_HOLD);
            if (state == ST_IDLE && next_state == ST_T1) begin
                kind     <= cyc_kind_in;
                addr_q   <= cyc_addr_in;
                wdata_q  <= cyc_wdata_in;
                onchip_q <= cyc_onchip_in;
            end
            if (in_refresh) begin
                refresh_addr <= refresh_addr + 7'h01;
            end
        end
    end

    assign cyc_ready_out = (state == ST_IDLE) && !hold_req && !slave_mode_in;

    // Strobe levels; each second-byte fetch is a separate fetch cycle
    wire next_memory_request_n_n = !((in_cycle && !is_io) || in_refresh);
    wire next_io_request_n_n = !(in_strobe && is_io);
    wire next_m1_n   = !(in_cycle && (is_fetch || is_iack));
    wire next_rd_n   = !(in_strobe && is_read);
    wire next_wr_n   = !(in_strobe && is_write);
    wire next_refresh_strobe_n_n = !in_refresh;
    wire bus_drive   = !floated && !(next_state == ST_HOLD);

    logic memory_request_n_q;
    logic io_request_n_q;
    logic m1_q;
    logic rd_q;
    logic wr_q;
    logic refresh_strobe_n_q;
    logic memory_request_n_oe;
    logic io_request_n_oe;
    logic m1_oe;
    logic rd_oe;
    logic wr_oe;
    logic refresh_strobe_n_oe;

    strobe_reg u_memory_request_n (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .next_level_n_in(next_memory_request_n_n), .next_drive_in(bus_drive),
        .level_n_out(memory_request_n_q), .drive_out(memory_request_n_oe));
    strobe_reg u_io_request_n (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .next_level_n_in(next_io_request_n_n), .next_drive_in(bus_drive),
        .level_n_out(io_request_n_q), .drive_out(io_request_n_oe));
    strobe_reg u_m1 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .next_level_n_in(next_m1_n), .next_drive_in(!emulation_float_mode_in),
        .level_n_out(m1_q), .drive_out(m1_oe));
    strobe_reg u_rd (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .next_level_n_in(next_rd_n), .next_drive_in(bus_drive),
        .level_n_out(rd_q), .drive_out(rd_oe));
    strobe_reg u_wr (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .next_level_n_in(next_wr_n), .next_drive_in(bus_drive),
        .level_n_out(wr_q), .drive_out(wr_oe));
    strobe_reg u_refresh_strobe_n (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .next_level_n_in(next_refresh_strobe_n_n), .next_drive_in(!emulation_float_mode_in),
        .level_n_out(refresh_strobe_n_q), .drive_out(refresh_strobe_n_oe));

    assign memory_request_n_out        = memory_request_n_q;
    assign memory_request_n_oe_out     = memory_request_n_oe;
    assign io_request_n_out            = io_request_n_q;
    assign io_request_n_oe_out         = io_request_n_oe;
    assign first_machine_cycle_n_out   = m1_q;
    assign first_machine_cycle_n_oe_out = m1_oe;
    assign read_n_out                  = rd_q;
    assign read_n_oe_out               = rd_oe;
    assign write_n_out                 = wr_q;
    assign write_n_oe_out              = wr_oe;
    assign refresh_strobe_n_out        = refresh_strobe_n_q;
    assign refresh_strobe_n_oe_out     = refresh_strobe_n_oe;
    assign hold_grant_n_out            = !hold_grant;

    // Address and data pins lag the state by one register, like the strobes
    logic [ADDR_W-1:0] addr_r;
    logic              addr_oe_r;
    logic [DATA_W-1:0] data_r;
    logic              data_oe_r;
    logic              done_r;
    logic [DATA_W-1:0] rdata_r;
    logic              srd_r;
    logic              swr_r;
    logic [ADDR_W-1:0] saddr_r;
    logic [DATA_W-1:0] swdata_r;

    wire [ADDR_W-1:0] refresh_word = {addr_q[ADDR_W-1:`REFRESH_ADDR_WIDTH], refresh_addr};
    wire [ADDR_W-1:0] next_addr = in_refresh ? refresh_word : addr_q;
    wire next_addr_oe = bus_drive && (in_cycle || in_refresh);
    wire next_data_oe = bus_drive && in_strobe && (is_write || onchip_q) && !is_iack;
    wire [DATA_W-1:0] next_data = (is_read && onchip_q) ? onchip_rdata_in : wdata_q;
    wire t3_end = (state == ST_T3);
    wire slave_act = floated && hold_grant == 1'b0 && slave_mode_in;
    wire s_rd = slave_act && !read_n_in && !io_request_n_in;
    wire s_wr = slave_act && !write_n_in && !io_request_n_in;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            addr_r    <= `ADDR_RESET;
            addr_oe_r <= 1'b0;
            data_r    <= `DATA_RESET;
            data_oe_r <= 1'b0;
            done_r    <= 1'b0;
            rdata_r   <= `DATA_RESET;
            srd_r     <= 1'b0;
            swr_r     <= 1'b0;
            saddr_r   <= `ADDR_RESET;
            swdata_r  <= `DATA_RESET;
        end else begin
            addr_r    <= next_addr;
            addr_oe_r <= next_addr_oe;
            data_r    <= next_data;
            data_oe_r <= next_data_oe;
            done_r    <= t3_end;
            if (t3_end) begin
                rdata_r <= onchip_q ? onchip_rdata_in : data_in;
            end
            srd_r    <= s_rd;
            swr_r    <= s_wr;
            saddr_r  <= addr_in;
            swdata_r <= data_in;
        end
    end

    assign addr_out        = addr_r;
    assign addr_oe_out     = addr_oe_r;
    assign data_out        = data_r;
    assign data_oe_out     = data_oe_r;
    assign cyc_done_out    = done_r;
    assign cyc_rdata_out   = rdata_r;
    assign slave_rd_out    = srd_r;
    assign slave_wr_out    = swr_r;
    assign slave_addr_out  = saddr_r;
    assign slave_wdata_out = swdata_r;

endmodule

// ==== core/bus_port_defines.svh ====
`ifndef BUS_PORT_DEFINES_SVH
`define BUS_PORT_DEFINES_SVH

`define ADDR_WIDTH 16
`define DATA_WIDTH 8
`define IO_ADDR_MSB 7
`define REFRESH_ADDR_WIDTH 7
`define STROBE_IDLE 1'b1
`define STROBE_ACTIVE 1'b0
`define ADDR_RESET 16'h0000
`define DATA_RESET 8'h00
`define REFRESH_RESET 7'h00

`endif

// ==== core/bus_port_pkg.sv ====
package bus_port_pkg;

    typedef enum logic [2:0] {
        CYC_FETCH      = 3'b000,
        CYC_MEM_READ   = 3'b001,
        CYC_MEM_WRITE  = 3'b010,
        CYC_IO_READ    = 3'b011,
        CYC_IO_WRITE   = 3'b100,
        CYC_INT_ACK    = 3'b101
    } cycle_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_T1      = 3'b001,
        ST_T2      = 3'b010,
        ST_TW      = 3'b011,
        ST_T3      = 3'b100,
        ST_REFRESH = 3'b101,
        ST_HOLD    = 3'b110
    } bus_state_t;

endpackage

// ==== core/strobe_reg.sv ====
`timescale 1ns/1ps
`include "bus_port_defines.svh"

// Active-low output flop with output enable; idles high
module strobe_reg (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic next_level_n_in,
    input  wire logic next_drive_in,
    output logic      level_n_out,
    output logic      drive_out
);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            level_n_out <= `STROBE_IDLE;
            drive_out   <= 1'b0;
        end else begin
            level_n_out <= next_level_n_in;
            drive_out   <= next_drive_in;
        end
    end

endmodule

// ==== verif/bus_port_checker_assertions.sv ====
`timescale 1ns/1ps
module bus_port_checker (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic cyc_done_out,
    input wire logic emulation_float_mode_in,
    input wire logic slave_mode_in,
    input wire logic addr_oe_out,
    input wire logic data_oe_out,
    input wire logic read_n_out,
    input wire logic write_n_out,
    input wire logic write_n_oe_out,
    input wire logic memory_request_n_out,
    input wire logic memory_request_n_oe_out,
    input wire logic io_request_n_out,
    input wire logic first_machine_cycle_n_out,
    input wire logic first_machine_cycle_n_oe_out,
    input wire logic refresh_strobe_n_out,
    input wire logic refresh_strobe_n_oe_out,
    input wire logic hold_grant_n_out,
    input wire logic wait_n_in
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    chk_reset_idle: assert property (disable iff (1'h0) sys_rst_in |=>
        read_n_out && write_n_out && memory_request_n_out && io_request_n_out
        && hold_grant_n_out && !addr_oe_out) else $error("not idle after reset");
    chk_fetch_m1: assert property ($fell(refresh_strobe_n_out) && refresh_strobe_n_oe_out
        |-> !$past(first_machine_cycle_n_out) && !$past(memory_request_n_out))
        else $error("refresh not after fetch");
    chk_refresh_memory_request_n: assert property (!refresh_strobe_n_out && refresh_strobe_n_oe_out
        |-> !memory_request_n_out && first_machine_cycle_n_out) else $error("lone refresh");
    chk_emu_float: assert property (emulation_float_mode_in && $past(emulation_float_mode_in)
        |-> !first_machine_cycle_n_oe_out && !refresh_strobe_n_oe_out)
        else $error("driven in float mode");
    chk_hold_float: assert property (!hold_grant_n_out |-> !addr_oe_out && !data_oe_out
        && !write_n_oe_out && !memory_request_n_oe_out) else $error("driven under hold");
    chk_wait_stall: assert property (!wait_n_in [*3] |-> !cyc_done_out)
        else $error("done during wait");
    chk_write_data: assert property (!write_n_out && write_n_oe_out |-> data_oe_out)
        else $error("write without data");
    chk_slave_float: assert property (slave_mode_in && $past(slave_mode_in)
        |-> !addr_oe_out && !memory_request_n_oe_out) else $error("driven in slave mode");
    cov_fetch: cover property (!refresh_strobe_n_out && refresh_strobe_n_oe_out);
    cov_hold: cover property (!hold_grant_n_out);
    cov_wait: cover property (!wait_n_in [*3]);
endmodule

bind cpu_external_bus_interface bus_port_checker u_chk (.*);

// ==== verif/ext_mem_model.sv ====
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        rd_n_in,
    input  wire logic        wr_n_in,
    input  wire logic        memory_request_n_n_in,
    input  wire logic [3:0]  stall_in,
    output logic      [7:0]  data_out,
    output logic             wait_n_out
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    logic [3:0] cnt = 4'h0;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
    // Released bus shows the inverse of the last byte
    assign data_out = rd_n_in ? ~last : mem[addr_in[7:0]];
    // Not ready for stall cycles from the start of each memory request
    assign wait_n_out = memory_request_n_n_in | (cnt == stall_in);
    always @(posedge clk_in) begin
        cnt <= memory_request_n_n_in ? 4'h0 : cnt + 4'(cnt != stall_in);
        if (!wr_n_in) mem[addr_in[7:0]] <= data_in;
        if (!rd_n_in) last <= mem[addr_in[7:0]];
    end
endmodule

// ==== verif/cpu_external_bus_interface_tb_top.sv ====
`timescale 1ns/1ps
module cpu_external_bus_interface_tb_top;
    import bus_port_pkg::*;
    logic clk_in = 1'h0, sys_rst_in = 1'h1, cyc_req_in = 1'h0, m_rd = 1'h1, cyc_onchip_in = 1'h0;
    logic emulation_float_mode_in = 1'h0, slave_mode_in = 1'h0, hold_request_n_in = 1'h1;
    logic m_wr = 1'h1;
    logic read_n_in, write_n_in, io_request_n_in, wait_n_in, cyc_ready_out, cyc_done_out;
    logic addr_oe_out, data_oe_out, read_n_out, read_n_oe_out, write_n_out, write_n_oe_out;
    logic memory_request_n_out, memory_request_n_oe_out, io_request_n_out, io_request_n_oe_out;
    logic first_machine_cycle_n_out, first_machine_cycle_n_oe_out, refresh_strobe_n_out;
    logic refresh_strobe_n_oe_out, hold_grant_n_out, slave_rd_out, slave_wr_out;
    cycle_kind_t cyc_kind_in = CYC_FETCH;
    logic [15:0] cyc_addr_in = 16'h0000, m_addr = 16'h0000, addr_in, addr_out, slave_addr_out;
    logic [7:0] cyc_wdata_in = 8'h00, onchip_rdata_in = 8'hC3, data_in, data_out, mem_q;
    logic [7:0] cyc_rdata_out, slave_wdata_out, a8, w;
    logic [3:0] stall = 4'h0;
    logic [6:0] tbl [6] = '{7'h65, 7'h60, 7'h28, 7'h50, 7'h18, 7'h02};
    int err_count = 0, n_tests = 0, seed = 32'h96B183A9, em [256];

    assign addr_in = addr_oe_out ? addr_out : m_addr;
    assign data_in = data_oe_out ? data_out : mem_q;
    assign read_n_in = read_n_oe_out ? read_n_out : m_rd;
    assign write_n_in = write_n_oe_out ? write_n_out : m_wr;
    assign io_request_n_in = io_request_n_oe_out ? io_request_n_out : (m_rd & m_wr);
    always #5 clk_in = ~clk_in;

    cpu_external_bus_interface dut (.*);
    ext_mem_model u_mem (.clk_in(clk_in), .addr_in(addr_in), .data_in(data_in),
        .rd_n_in(read_n_in), .wr_n_in(write_n_in),
        .memory_request_n_n_in(memory_request_n_out | !memory_request_n_oe_out),
        .stall_in(stall), .data_out(mem_q),
        .wait_n_out(wait_n_in));

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic print_verdict;
        $display("compares %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One core cycle; flags collect which strobe combinations showed up
    task automatic run(input cycle_kind_t k, input logic [15:0] a, input logic [3:0] st);
        logic [6:0] f;
        int         n;
        int         d;
        f = 7'h00;
        d = 0;
        stall = st;
        for (n = 0; n < 20 && !cyc_ready_out; n++) @(negedge clk_in);
        if (!cyc_ready_out) err_count++;
        cyc_req_in = 1'h1;
        cyc_kind_in = k;
        cyc_addr_in = a;
        cyc_wdata_in = w;
        @(negedge clk_in);
        cyc_req_in = 1'h0;
        // Sample one cycle past done so that the refresh slot is seen too
        for (n = 1; n < 40 && (d == 0 || n <= d + 1); n++) begin
            f |= {!read_n_out, !memory_request_n_out && addr_oe_out && addr_out === a,
                  !io_request_n_out && memory_request_n_out && first_machine_cycle_n_out
                  && addr_out[7:0] === a[7:0], !write_n_out && data_oe_out && data_out === w,
                  !refresh_strobe_n_out && refresh_strobe_n_oe_out && !memory_request_n_out,
                  !io_request_n_out && !first_machine_cycle_n_out, !first_machine_cycle_n_out
                  && first_machine_cycle_n_oe_out && !memory_request_n_out};
            if (cyc_done_out && d == 0) d = n;
            @(negedge clk_in);
        end
        cmp(16'(d), 16'(4 + st));
        cmp({9'h000, f}, {9'h000, tbl[k] & (emulation_float_mode_in ? 7'h7A : 7'h7F)});
        if (k == CYC_MEM_WRITE || k == CYC_IO_WRITE) em[a[7:0]] = int'(w);
        a8 = cyc_onchip_in ? onchip_rdata_in : 8'(em[a[7:0]]);
        if (k == CYC_FETCH || k == CYC_MEM_READ || k == CYC_IO_READ)
            cmp({8'h00, cyc_rdata_out}, {8'h00, a8});
    endtask

    initial begin
        logic [15:0] a;
        for (int i = 0; i < 256; i++) em[i] = (i * 7 + 3) % 256;
        w = 8'h00;
        repeat (3) @(negedge clk_in);
        cmp({8'h00, read_n_out, write_n_out, memory_request_n_out, io_request_n_out,
             hold_grant_n_out, addr_oe_out, data_oe_out, cyc_done_out}, 16'h00F8);
        sys_rst_in = 1'h0;
        for (int i = 0; i < 2; i++) run(CYC_FETCH, 16'($random(seed)), 4'h0);
        for (int k = 0; k < 6; k++) begin
            w = 8'($random(seed));
            run(cycle_kind_t'(k), 16'($random(seed)), 4'h0);
        end
        a = 16'($random(seed));
        w = 8'($random(seed));
        run(CYC_MEM_WRITE, a, 4'h0);
        run(CYC_MEM_READ, a, 4'h3);
        emulation_float_mode_in = 1'h1;
        run(CYC_FETCH, a, 4'h0);
        emulation_float_mode_in = 1'h0;
        cyc_onchip_in = 1'h1;
        run(CYC_IO_READ, a, 4'h0);
        cyc_onchip_in = 1'h0;
        hold_request_n_in = 1'h0;
        for (int i = 0; i < 10 && hold_grant_n_out; i++) @(negedge clk_in);
        cmp({9'h000, hold_grant_n_out, addr_oe_out, data_oe_out, read_n_oe_out, write_n_oe_out,
             memory_request_n_oe_out, io_request_n_oe_out}, 16'h0000);
        hold_request_n_in = 1'h1;
        for (int i = 0; i < 10 && !hold_grant_n_out; i++) @(negedge clk_in);
        cmp({15'h0000, hold_grant_n_out}, 16'h0001);
        m_addr = 16'($random(seed));
        slave_mode_in = 1'h1;
        m_rd = 1'h0;
        repeat (3) @(negedge clk_in);
        cmp({13'h0000, addr_oe_out, memory_request_n_oe_out, slave_rd_out}, 16'h0001);
        cmp(slave_addr_out, m_addr);
        m_rd = 1'h1;
        m_wr = 1'h0;
        repeat (2) @(negedge clk_in);
        cmp({14'h0000, slave_rd_out, slave_wr_out}, 16'h0001);
        cmp({8'h00, slave_wdata_out}, {8'h00, ~8'(em[m_addr[7:0]])});
        m_wr = 1'h1;
        slave_mode_in = 1'h0;
        print_verdict();
    end
endmodule
